//--- ascp_cmd_port.sv
// Purpose: Serial command front end of the converter
// Assumes: Host shifts on falling sclk edge, device samples on rising
// Notes:   DOUT doubles as a ready-low flag when not shifting

`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - Command register is write only, never read
// - Command fixes next transfer, then await command
// - After reset, interface awaits command byte
// - Thirty-two ones on input reset everything
// - Command bits arrive most significant first
// - Leading one holds; zero gates seven bits
// - Bit six picks write or read
// - Bits five to three select register
// - Continuous bit with data select on a read streams data
// - Continuous mode still watches for commands
// - Command register resets to zero
// - Select codes map to fixed register lengths
module ascp_cmd_port
   import ascp_pkg::*;
(
   input  wire logic              clk_i,      // 25 MHz clock
   input  wire logic              resetn_i,   // Sync reset, active low
   input  wire logic              sclk_i,     // Serial clock pin
   input  wire logic              din_i,      // Serial data in pin
   output var  logic              dout_o,     // Serial data out / ready
   input  wire logic              conv_rdy_i, // New conversion waiting
   output var  logic [2:0]        rd_sel_o,   // Register being read
   input  wire logic [DATA_W-1:0] rd_data_i,  // Read data, right aligned
   output var  logic              rd_done_o,  // Read finished pulse
   output var  logic              wr_stb_o,   // Write data valid pulse
   output var  logic [2:0]        wr_sel_o,   // Register being written
   output var  logic [DATA_W-1:0] wr_data_o,  // Write data, right aligned
   output var  logic              cont_o,     // Continuous read active
   output var  logic              part_rst_o  // Whole part reset pulse
);

   import ascp_pkg::*;

   ascp_edge_if edges ();

   ascp_pin_sampler u_sampler (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .sclk_i   (sclk_i),
      .din_i    (din_i),
      .edges    (edges.src)
   );

   logic ones_rst;

   ascp_ones_det u_ones (
      .clk_i      (clk_i),
      .resetn_i   (resetn_i),
      .edges      (edges.dst),
      .part_rst_o (ones_rst)
   );

   ascp_state_t       state;
   logic [7:0]        command_byte_reg;
   logic              cmd_open;
   logic [2:0]        cmd_cnt;
   logic [5:0]        cmd_sh;
   logic [DATA_W-1:0] sh;
   logic [4:0]        bit_cnt;
   logic [4:0]        xfer_len;
   logic              loaded;
   logic              cont_busy;
   logic              cont_armed;
   logic              rst_all;
   logic              rise;
   logic              cmd_take;
   logic [7:0]        next_cmd;
   logic [2:0]        next_sel;
   logic              cont_exit;
   logic              rd_last;
   logic              wr_last;
   logic              cont_last;
   logic              cont_load;

   assign rst_all  = !resetn_i || ones_rst;
   assign rise     = edges.sclk_rise;

   // Command capture runs in idle and in continuous mode alike
   assign cmd_take = rise && cmd_open && (cmd_cnt == 3'h6)
                     && (state == ST_CMD || state == ST_CONT);
   assign next_cmd = {1'b0, cmd_sh, edges.din};
   assign next_sel = next_cmd[RS_MSB:RS_LSB];
   assign cont_exit = next_cmd[RW_POS] && (next_sel == SEL_DATA)
                      && !next_cmd[CONTINUOUS_FETCH_BIT_POS];

   assign rd_last   = rise && loaded && (state == ST_RD)
                      && (bit_cnt == xfer_len - 5'h01);
   assign wr_last   = rise && (state == ST_WR)
                      && (bit_cnt == xfer_len - 5'h01);
   assign cont_last = rise && cont_busy && (bit_cnt == LEN_24 - 5'h01);
   assign cont_load = (state == ST_CONT) && !cont_busy && cont_armed
                      && conv_rdy_i;

   always_ff @(posedge clk_i) begin
      if (rst_all) begin
         cmd_open <= 1'b0;
         cmd_cnt  <= 3'h0;
         cmd_sh   <= 6'h00;
      end else if (state == ST_WR || state == ST_RD) begin
         cmd_open <= 1'b0;
         cmd_cnt  <= 3'h0;
      end else if (rise) begin
         if (!cmd_open) begin
            cmd_open <= !edges.din;
            cmd_cnt  <= 3'h0;
         end else if (cmd_take) begin
            cmd_open <= 1'b0;
            cmd_cnt  <= 3'h0;
         end else begin
            cmd_sh  <= {cmd_sh[4:0], edges.din};
            cmd_cnt <= cmd_cnt + 3'h1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_all) begin
         command_byte_reg <= CMD_RESET;
      end else if (cmd_take && state == ST_CMD) begin
         command_byte_reg <= next_cmd;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_all) begin
         state    <= ST_CMD;
         xfer_len <= LEN_8;
         rd_sel_o <= SEL_STATUS;
         wr_sel_o <= SEL_STATUS;
      end else begin
         unique case (state)
            ST_CMD: begin
               if (cmd_take) begin
                  xfer_len <= ascp_reg_len(next_sel);
                  if (!next_cmd[RW_POS]) begin
                     wr_sel_o <= next_sel;
                     // Selecting the command slot again just re-arms
                     if (next_sel != CMD_OFFSET) begin
                        state <= ST_WR;
                     end
                  end else begin
                     rd_sel_o <= next_sel;
                     if (next_sel == SEL_DATA && next_cmd[CONTINUOUS_FETCH_BIT_POS]) begin
                        state <= ST_CONT;
                     end else begin
                        state <= ST_RD;
                     end
                  end
               end
            end
            ST_WR: begin
               if (wr_last) begin
                  state <= ST_CMD;
               end
            end
            ST_RD: begin
               if (rd_last) begin
                  state <= ST_CMD;
               end
            end
            ST_CONT: begin
               // Anything but the exit command is dropped
               if (cmd_take && cont_exit) begin
                  state    <= ST_RD;
                  xfer_len <= LEN_24;
                  rd_sel_o <= SEL_DATA;
               end
            end
         endcase
      end
   end

   // One shift register serves reads, writes and streaming
   always_ff @(posedge clk_i) begin
      if (rst_all) begin
         sh         <= '0;
         bit_cnt    <= 5'h00;
         loaded     <= 1'b0;
         cont_busy  <= 1'b0;
         cont_armed <= 1'b1;
      end else begin
         unique case (state)
            ST_CMD: begin
               // Cleared so short writes stay right aligned
               sh        <= '0;
               bit_cnt   <= 5'h00;
               loaded    <= 1'b0;
               cont_busy <= 1'b0;
            end
            ST_WR: begin
               if (rise) begin
                  sh      <= {sh[DATA_W-2:0], edges.din};
                  bit_cnt <= bit_cnt + 5'h01;
               end
            end
            ST_RD: begin
               cont_busy <= 1'b0;
               // rd_sel_o settled a cycle ago; sclk is far slower
               if (!loaded) begin
                  sh      <= rd_data_i << (5'(DATA_W) - xfer_len);
                  bit_cnt <= 5'h00;
                  loaded  <= 1'b1;
               end else if (rise) begin
                  sh      <= {sh[DATA_W-2:0], 1'b0};
                  bit_cnt <= bit_cnt + 5'h01;
               end
            end
            ST_CONT: begin
               loaded <= 1'b0;
               if (!conv_rdy_i) begin
                  cont_armed <= 1'b1;
               end
               if (cont_load) begin
                  sh         <= rd_data_i;
                  bit_cnt    <= 5'h00;
                  cont_busy  <= 1'b1;
                  cont_armed <= 1'b0;
               end else if (rise && cont_busy) begin
                  sh      <= {sh[DATA_W-2:0], 1'b0};
                  bit_cnt <= bit_cnt + 5'h01;
                  if (cont_last) begin
                     cont_busy <= 1'b0;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_all) begin
         wr_stb_o  <= 1'b0;
         wr_data_o <= '0;
         rd_done_o <= 1'b0;
      end else begin
         wr_stb_o  <= wr_last;
         rd_done_o <= rd_last || cont_last;
         if (wr_last) begin
            wr_data_o <= {sh[DATA_W-2:0], edges.din};
         end
      end
   end

   // Idle output shows ready low so the host can poll the pin
   always_ff @(posedge clk_i) begin
      if (rst_all) begin
         dout_o <= 1'b1;
      end else if ((state == ST_RD && loaded) || cont_busy) begin
         dout_o <= sh[DATA_W-1];
      end else begin
         dout_o <= !conv_rdy_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         cont_o     <= 1'b0;
         part_rst_o <= 1'b0;
      end else begin
         cont_o     <= (state == ST_CONT) && !ones_rst;
         part_rst_o <= ones_rst;
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);

   a_cmd_reset_zero: assert property (
      ones_rst |=> command_byte_reg == CMD_RESET)
      else $error("command register not cleared by reset");

   a_wen_gate_hold: assert property (
      (state == ST_CMD) && !cmd_open && rise && edges.din && !ones_rst
      |=> !cmd_open && cmd_cnt == 3'h0)
      else $error("leading one did not hold the command gate");

   a_ones_to_idle: assert property (
      ones_rst |=> state == ST_CMD && !cmd_open && part_rst_o)
      else $error("ones run did not return to idle");

   a_write_dir: assert property (
      $rose(state == ST_WR) |-> !command_byte_reg[RW_POS]
      && wr_sel_o == command_byte_reg[RS_MSB:RS_LSB])
      else $error("write started without write direction");

   a_write_return: assert property (
      wr_stb_o |-> state == ST_CMD && wr_sel_o != CMD_OFFSET)
      else $error("write did not return to command wait");

   a_read_len: assert property (
      $rose(state == ST_RD) |-> xfer_len == ascp_reg_len(rd_sel_o))
      else $error("read length does not match select");

   a_cont_entry: assert property (
      cmd_take && state == ST_CMD && !ones_rst && next_cmd[RW_POS]
      && next_sel == SEL_DATA && next_cmd[CONTINUOUS_FETCH_BIT_POS]
      |=> state == ST_CONT ##1 cont_o)
      else $error("continuous read not entered");

   a_cont_hold: assert property (
      state == ST_CONT && cmd_take && !cont_exit && !ones_rst
      |=> state == ST_CONT)
      else $error("continuous mode left by wrong command");

   a_cont_exit: assert property (
      state == ST_CONT && cmd_take && cont_exit && !ones_rst
      |=> state == ST_RD && rd_sel_o == SEL_DATA)
      else $error("continuous mode exit failed");

   a_read_done: assert property (
      rd_last && !ones_rst |=> rd_done_o && state == ST_CMD)
      else $error("read did not finish cleanly");

   c_cont_mode: cover property ($rose(cont_o));
   c_cont_word: cover property (cont_last);
   c_reg_write: cover property (wr_stb_o);
   c_reg_read: cover property (rd_last);
   c_ones_reset: cover property (ones_rst);

endmodule : ascp_cmd_port

`default_nettype wire

//--- ascp_edge_if.sv
// Purpose: Carries sampled serial clock edges and data bit
// Assumes: Driven by the pin sampler only
// Notes:   sclk_rise is one clk_i cycle wide; din is a level

`timescale 1ns/100ps
`default_nettype none

interface ascp_edge_if;
   logic sclk_rise;
   logic din;

   modport src (output sclk_rise, output din);
   modport dst (input sclk_rise, input din);
endinterface : ascp_edge_if

`default_nettype wire

//--- ascp_host_model.sv
// Purpose: Behavioural serial master driving the command port
// Assumes: Mode 3 link, sclk idles high, 320 ns bit period
// Notes:   sclk stands still between frames

`timescale 1ns/100ps
`default_nettype none

module ascp_host_model (
   input  wire logic clk_i,   // System clock
   output var  logic sclk_o,  // Serial clock, idles high
   output var  logic din_o,   // Serial data to device
   input  wire logic dout_i   // Serial data from device
);
   initial begin
      sclk_o = 1'b1;
      din_o  = 1'b0;
   end

   // Host changes din on fall, both sides sample on rise, MSB first
   task automatic shift(input logic [39:0] val, input int n, output logic [39:0] got);
      got = '0;
      for (int i = n - 1; i >= 0; i--) begin
         @(posedge clk_i);
         sclk_o <= 1'b0;
         din_o  <= val[i];
         repeat (4) @(posedge clk_i);
         got[i] = dout_i;
         sclk_o <= 1'b1;
         repeat (3) @(posedge clk_i);
      end
      // Released line shows the inverse so a stale value cannot pass
      din_o <= ~din_o;
   endtask : shift
endmodule : ascp_host_model

`default_nettype wire

//--- ascp_ones_det.sv
// Purpose: Spots a run of ones on the data line, counted on sclk rising edges
// Assumes: Data sampled on serial clock rising edges
// Notes:   Runs in every state, so long writes of ones also reset

`timescale 1ns/100ps
`default_nettype none

module ascp_ones_det
   import ascp_pkg::*;
(
   input  wire logic clk_i,       // System clock
   input  wire logic resetn_i,    // Sync reset, active low
   ascp_edge_if.dst  edges,       // Sampled edges in
   output var  logic part_rst_o   // One-cycle reset pulse
);

   logic [5:0] ones_cnt;

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         ones_cnt   <= 6'h00;
         part_rst_o <= 1'b0;
      end else begin
         part_rst_o <= 1'b0;
         if (edges.sclk_rise) begin
            if (!edges.din) begin
               ones_cnt <= 6'h00;
            end else if (ones_cnt == ONES_LIMIT - 6'h01) begin
               ones_cnt   <= 6'h00;
               part_rst_o <= 1'b1;
            end else begin
               ones_cnt <= ones_cnt + 6'h01;
            end
         end
      end
   end

endmodule : ascp_ones_det

`default_nettype wire

//--- ascp_pin_sampler.sv
// Purpose: Brings serial clock and data pins into the clk_i domain
// Assumes: Serial clock far slower than clk_i
// Notes:   Edges come from the second stage only

`timescale 1ns/100ps
`default_nettype none

module ascp_pin_sampler (
   input  wire logic clk_i,     // System clock
   input  wire logic resetn_i,  // Sync reset, active low
   input  wire logic sclk_i,    // Serial clock pin
   input  wire logic din_i,     // Serial data pin
   ascp_edge_if.src  edges      // Sampled edges out
);

   logic [1:0] pins;
   logic [1:0] meta;
   logic [1:0] sync;
   logic       sclk_prev;

   assign pins = {din_i, sclk_i};

   // Both pins in one process so each vector has a single writer
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         meta <= 2'h3;
         sync <= 2'h3;
      end else begin
         meta <= pins;
         sync <= meta;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         sclk_prev <= 1'b1;
      end else begin
         sclk_prev <= sync[0];
      end
   end

   assign edges.sclk_rise = sync[0] & ~sclk_prev;
   assign edges.din       = sync[1];

endmodule : ascp_pin_sampler

`default_nettype wire

//--- ascp_pkg.sv
// Purpose: Shared constants and types of the serial command port
// Assumes: Widths fixed to the widest register variant
// Notes:   Register lengths are counted in serial bits

`default_nettype none

package ascp_pkg;

   localparam int          CMD_W       = 8;
   localparam int          DATA_W      = 24;
   localparam int          WEN_POS     = 7;
   localparam int          RW_POS      = 6;
   localparam int          RS_MSB      = 5;
   localparam int          RS_LSB      = 3;
   localparam int          CONTINUOUS_FETCH_BIT_POS   = 2;
   localparam logic [7:0]  CMD_RESET   = 8'h00;
   localparam logic [5:0]  ONES_LIMIT  = 6'h20;

   // Register select codes
   localparam logic [2:0]  CMD_OFFSET  = 3'h0;
   localparam logic [2:0]  SEL_STATUS  = 3'h0;
   localparam logic [2:0]  SEL_MODE    = 3'h1;
   localparam logic [2:0]  SEL_CONFIG  = 3'h2;
   localparam logic [2:0]  SEL_DATA    = 3'h3;
   localparam logic [2:0]  SEL_ID      = 3'h4;
   localparam logic [2:0]  SEL_IO      = 3'h5;
   localparam logic [2:0]  SEL_OFFSET  = 3'h6;
   localparam logic [2:0]  SEL_FSCALE  = 3'h7;

   localparam logic [4:0]  LEN_8       = 5'h08;
   localparam logic [4:0]  LEN_16      = 5'h10;
   localparam logic [4:0]  LEN_24      = 5'h18;

   typedef enum logic [3:0] {
      ST_CMD  = 4'b0001,
      ST_WR   = 4'b0010,
      ST_RD   = 4'b0100,
      ST_CONT = 4'b1000
   } ascp_state_t;

   function automatic logic [4:0] ascp_reg_len(input logic [2:0] sel);
      logic [4:0] len;
      len = LEN_8;
      unique case (sel)
         SEL_MODE, SEL_CONFIG:              len = LEN_16;
         SEL_DATA, SEL_OFFSET, SEL_FSCALE:  len = LEN_24;
         SEL_STATUS, SEL_ID, SEL_IO:        len = LEN_8;
      endcase
      return len;
   endfunction : ascp_reg_len

endpackage : ascp_pkg

`default_nettype wire

//--- testbench.sv
// Purpose: Self-checking bench for the serial command port
// Assumes: Converter side driven by the bench itself
// Notes:   Transfers open with a command byte, except streamed words and ones runs

`timescale 1ns/100ps
`default_nettype none

module testbench;
   import ascp_pkg::*;

   logic              clk;
   logic              resetn_i;
   logic              sclk;
   logic              din;
   logic              dout;
   logic              conv_rdy;
   logic [2:0]        rd_sel;
   logic [2:0]        wr_sel;
   logic [DATA_W-1:0] rd_data;
   logic [DATA_W-1:0] wr_data;
   logic              rd_done;
   logic              wr_stb;
   logic              cont;
   logic              part_rst;
   int                n_errors = 0;
   int                check_count = 0;
   int                n_wr = 0;
   int                n_rd = 0;
   int                n_rst = 0;
   int                len;
   int                nw;
   int                nr;
   int                nrst;
   logic [2:0]        sel;
   logic [2:0]        last_wsel;
   logic [2:0]        last_rsel;
   logic [DATA_W-1:0] last_wdata;
   logic [23:0]       pat;
   logic [39:0]       got;

   ascp_cmd_port i_ascp_cmd_port (
      .clk_i(clk), .resetn_i(resetn_i), .sclk_i(sclk), .din_i(din), .dout_o(dout),
      .conv_rdy_i(conv_rdy), .rd_sel_o(rd_sel), .rd_data_i(rd_data), .rd_done_o(rd_done),
      .wr_stb_o(wr_stb), .wr_sel_o(wr_sel), .wr_data_o(wr_data), .cont_o(cont),
      .part_rst_o(part_rst)
   );

   ascp_host_model i_ascp_host_model (
      .clk_i(clk), .sclk_o(sclk), .din_o(din), .dout_i(dout)
   );

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Pulses last one cycle, so count them where they happen
   always @(posedge clk) begin
      if (wr_stb === 1'b1) begin
         n_wr++;
         last_wsel  = wr_sel;
         last_wdata = wr_data;
      end
      if (rd_done === 1'b1) begin
         n_rd++;
         last_rsel = rd_sel;
      end
      if (part_rst === 1'b1) n_rst++;
   end

   task automatic check(input logic [39:0] seen, input logic [39:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
      end
   endtask : check

   function automatic int len_of(input logic [2:0] s);
      case (s)
         3'h1, 3'h2:       return 16;
         3'h3, 3'h6, 3'h7: return 24;
         default:          return 8;
      endcase
   endfunction : len_of

   task automatic xfer(input logic [39:0] val, input int n);
      i_ascp_host_model.shift(val, n, got);
      repeat (8) @(posedge clk);
   endtask : xfer

   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : summarize

   initial begin
      repeat (40000) @(posedge clk);
      n_errors++;
      $display("unexpected at %0t: watchdog expired", $time);
      summarize();
   end

   initial begin
      resetn_i = 1'b0;
      conv_rdy = 1'b0;
      rd_data  = '0;
      repeat (4) @(posedge clk);
      resetn_i <= 1'b1;
      repeat (4) @(posedge clk);
      check(40'(dout), 40'h1, "idle ready");
      check(40'({cont, wr_sel, wr_data}), 40'h0, "reset outputs");
      $display("test reset done");

      // Two leading ones must be held off by the gate
      xfer({14'h0, 2'b11, 8'h08, 16'hA5C3}, 26);
      check(40'(n_wr), 40'h1, "gated write count");
      check(40'(last_wsel), 40'(SEL_MODE), "gated write select");
      check(40'(last_wdata), 40'h00A5C3, "gated write data");
      $display("test gate done");

      for (int s = 0; s < 8; s++) begin
         sel = s[2:0];
         len = len_of(sel);
         nw  = n_wr;
         nr  = n_rd;
         pat = 24'hC35A96 >> (24 - len);
         if (sel == 3'h0) begin
            xfer(40'h00, 8);
            check(40'(n_wr), 40'(nw), "write to command slot");
         end else begin
            xfer((40'({2'b00, sel, 3'b000}) << len) | 40'(pat), 8 + len);
            check(40'(n_wr), 40'(nw + 1), "write count");
            check(40'(last_wsel), 40'(sel), "write select");
            check(40'(last_wdata), 40'(pat), "write data length");
         end
         pat = 24'h3C96A5 >> (24 - len);
         rd_data <= pat;
         xfer(40'({2'b01, sel, 3'b000}) << len, 8 + len);
         check(got & ((40'h1 << len) - 40'h1), 40'(pat), "read data");
         check(40'(last_rsel), 40'(sel), "read select");
         check(40'(n_rd), 40'(nr + 1), "read count");
      end
      $display("test sweep done");

      rd_data  <= 24'h123456;
      conv_rdy <= 1'b1;
      xfer(40'h5C, 8);
      check(40'(cont), 40'h1, "continuous on");
      nr = n_rd;
      repeat (4) @(posedge clk);
      xfer(40'h0, 24);
      conv_rdy <= 1'b0;
      check(got, 40'h123456, "streamed word");
      check(40'(n_rd), 40'(nr + 1), "streamed count");
      nw = n_wr;
      xfer(40'h08, 8);
      check(40'(cont), 40'h1, "write ignored keeps mode");
      check(40'(n_wr), 40'(nw), "no write in mode");
      rd_data <= 24'h0F0F0F;
      xfer(40'h58 << 24, 32);
      check(40'(cont), 40'h0, "continuous off");
      check(got & 40'hFFFFFF, 40'h0F0F0F, "exit read");
      $display("test continuous done");

      conv_rdy <= 1'b1;
      xfer(40'h5C, 8);
      nrst = n_rst;
      xfer(40'hFFFFFFFF, 32);
      conv_rdy <= 1'b0;
      check(40'(n_rst), 40'(nrst + 1), "ones reset");
      check(40'(cont), 40'h0, "mode cleared by reset");
      nrst = n_rst;
      nw   = n_wr;
      xfer(40'h7FFFFFFF, 31);
      xfer(40'h283E, 16);
      check(40'(n_rst), 40'(nrst), "31 ones no reset");
      check(40'(n_wr), 40'(nw + 1), "write after ones");
      check(40'(last_wdata), 40'h3E, "data after ones");
      $display("test ones done");
      summarize();
   end
endmodule : testbench

`default_nettype wire
